// ==== rtl/dde_engine.sv ====
// file: descriptor interpreter for rx ring walk and tx status/ownership
// Function
// - ring wrap flag bit 25 sends next fetch back to list base.
// - chained flag bit 24 makes word three the next descriptor address.
// - ring wrap wins over chained when both are set.
// - second buffer size bits 21:11; zero skips to next descriptor.
// - first buffer size bits 10:0; zero skips to second buffer.
// - in chained mode the second size field is ignored.
// - completion status forces or invalidates flags per reception case.
// - tx bit 31 gives ownership; nobody uses what it does not own.
// - device clears tx ownership when frame or buffers are done.
// - tx error summary bit 15 is OR of six error flags.
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
module dde_engine import dde_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [31:0] buf_addr_o,
  output logic [BS_W-1:0] buf_size_o,
  output logic buf_valid_o,
  input wire logic buf_ready_i,
  output logic tx_own_o
);
  logic [31:0] base_q, next_q, rx_stat_q, tx_w0_q, tx_err_q, cond_q;
  logic [31:0] rdata_d;
  logic ack_q;
  logic pend_q;
  logic [31:0] mem_rdata;
  logic [31:0] rx_ctl_q;
  logic [31:0] mem_rdata_w2_q, mem_rdata_w3_q;
  dde_step_t step_q;
  logic busy_q;
  logic [BS_W-1:0] sz1_q, sz2_q;
  logic [31:0] a1_q, a2_q;
  logic wrap_q, chain_q;
  logic fifo_in_ready;
  logic [FIFO_W-1:0] fifo_out;
  logic fifo_out_valid;
  logic [BS_W-1:0] size_out_q;
  logic out_valid_q;
  logic [31:0] out_addr_q;

  wire acc = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr = acc && wb_we_i;
  wire wr_cmd = wr && wb_adr_i == REG_CMD;
  wire [3:0] wsel = wb_sel_i;
  // words land on the edge that raises ack, like every other register
  wire mem_we = wr && pend_q && (wb_adr_i == REG_RX_W1 ||
                                 wb_adr_i == REG_RX_W2 ||
                                 wb_adr_i == REG_RX_W3);
  wire base_wr = wr && pend_q && wb_adr_i == REG_RX_BASE;
  wire [1:0] mem_waddr = wb_adr_i[3:2];

  // read address straight off the bus: the word is registered by the ack edge
  dde_desc_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(wb_dat_i),
    .raddr_i(mem_waddr),
    .rdata_o(mem_rdata)
  );

  // rx control decode from the latched descriptor words
  wire [31:0] ctl = rx_ctl_q;
  wire ctl_wrap = ctl[RX_RING_WRAP_BIT];
  wire ctl_chain = ctl[RX_CHAINED_BIT];
  wire [BS_W-1:0] ctl_bs1 = ctl[RX_BS1_HI:RX_BS1_LO];
  wire [BS_W-1:0] ctl_bs2 = ctl[RX_BS2_HI:RX_BS2_LO];
  // next descriptor: wrap beats chain, chain uses word three
  wire [31:0] nxt_addr = wrap_q ? base_q :
                         chain_q ? a2_q :
                         next_q + DESC_STRIDE;
  // in chained mode buffer two does not exist at all
  wire use_buf2 = !chain_q && (sz2_q != '0);
  wire push_ok = fifo_in_ready;
  wire [FIFO_W-1:0] push_data = (step_q == DDE_BUF1) ? a1_q : a2_q;
  wire push_v = busy_q && ((step_q == DDE_BUF1 && sz1_q != '0) ||
                           (step_q == DDE_BUF2 && use_buf2));

  // rx completion status flag masking by reception case
  wire c_of = cond_q[COND_OVERFLOW];
  wire c_lc = cond_q[COND_LATE_COL];
  wire c_wd = cond_q[COND_WATCHDOG];
  wire c_sr = cond_q[COND_SHORT_RUNT];
  logic [31:0] stat_masked;
  always_comb begin
    stat_masked = rx_stat_q;
    if (c_of || c_lc || c_wd) begin
      stat_masked[RX_RF_BIT] = 1'b0;
    end
    if (c_of) begin
      stat_masked[RX_CS_BIT] = 1'b0;
    end
    if (c_of || c_wd) begin
      stat_masked[RX_DB_BIT] = 1'b0; // invalid: reported as clear
      stat_masked[RX_CE_BIT] = 1'b0;
    end
    if (c_sr) begin
      stat_masked[RX_FT_BIT] = 1'b0; // invalid under 14 bytes
      stat_masked[RX_FF_BIT] = 1'b0;
    end
  end

  // tx error summary
  wire tx_es = tx_err_q[TX_UNDERFLOW_BIT] | tx_err_q[TX_EXC_COL_BIT] |
               tx_err_q[TX_LATE_COL_BIT] | tx_err_q[TX_NO_CAR_BIT] |
               tx_err_q[TX_LOSS_CAR_BIT] | tx_err_q[TX_JABBER_BIT];
  logic [31:0] tx_view;
  always_comb begin
    tx_view = tx_err_q;
    tx_view[TX_ES_BIT] = tx_es;
    tx_view[TX_OWN_BIT] = tx_w0_q[TX_OWN_BIT];
  end

  always_comb begin
    case (wb_adr_i)
      REG_RX_BASE: rdata_d = base_q;
      REG_RX_W1, REG_RX_W2, REG_RX_W3: rdata_d = mem_rdata;
      REG_RX_NEXT: rdata_d = next_q;
      REG_RX_BUF: rdata_d = out_addr_q;
      REG_TX_W0, REG_TX_ERR: rdata_d = tx_view;
      REG_RX_STAT: rdata_d = stat_masked;
      REG_STATE: rdata_d = {29'h0000_0000, busy_q, fifo_out_valid,
                            fifo_in_ready};
      REG_RX_COND: rdata_d = cond_q;
      default: rdata_d = BAD_ADDR_DATA;
    endcase
  end

  // wishbone: two wait cycles before ack so the memory read register can settle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
      ack_q <= 1'b0;
      wb_dat_o <= RST_WORD;
    end else begin
      ack_q <= pend_q;
      pend_q <= acc && !pend_q;
      if (pend_q) begin
        wb_dat_o <= rdata_d;
      end
    end
  end
  assign wb_ack_o = ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_q <= RST_WORD;
      rx_ctl_q <= RST_WORD;
      rx_stat_q <= RST_WORD;
      tx_err_q <= RST_WORD;
      cond_q <= RST_WORD;
    end else if (wr && pend_q) begin
      for (int b = 0; b < 4; b++) begin
        if (wsel[b]) begin
          case (wb_adr_i)
            REG_RX_BASE: base_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
            REG_RX_W1: rx_ctl_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
            REG_TX_ERR: tx_err_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
            REG_RX_STAT: rx_stat_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
            REG_RX_COND: cond_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
            default: ;
          endcase
        end
      end
    end
  end

  // tx ownership: software sets it, device clears on completion
  wire tx_done = wr_cmd && pend_q && wb_dat_i[CMD_TX_DONE];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_w0_q <= RST_WORD;
    end else if (tx_done && tx_w0_q[TX_OWN_BIT]) begin
      tx_w0_q[TX_OWN_BIT] <= 1'b0;
    end else if (wr && pend_q && wb_adr_i == REG_TX_W0 && wsel[3]) begin
      tx_w0_q <= wb_dat_i;
    end
  end

  // rx step: latch the descriptor, then walk buffer1, buffer2, next
  wire start = wr_cmd && pend_q && wb_dat_i[CMD_RX_STEP] && !busy_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      step_q <= DDE_BUF1;
      next_q <= RST_WORD;
      sz1_q <= '0;
      sz2_q <= '0;
      a1_q <= RST_WORD;
      a2_q <= RST_WORD;
      wrap_q <= 1'b0;
      chain_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
      step_q <= DDE_BUF1;
      sz1_q <= ctl_bs1;
      sz2_q <= ctl_bs2;
      wrap_q <= ctl_wrap;
      chain_q <= ctl_chain;
      a1_q <= mem_rdata_w2_q;
      a2_q <= mem_rdata_w3_q;
    end else if (busy_q) begin
      case (step_q)
        DDE_BUF1: begin
          if (!push_v || push_ok) begin
            step_q <= DDE_BUF2; // zero size skips to buffer two
          end
        end
        DDE_BUF2: begin
          if (!push_v || push_ok) begin
            step_q <= DDE_NEXT; // zero size goes to next
          end
        end
        DDE_NEXT: begin
          next_q <= nxt_addr;
          busy_q <= 1'b0;
          step_q <= DDE_BUF1;
        end
        default: step_q <= DDE_BUF1;
      endcase
    end else if (base_wr) begin
      // a new list starts at its base, so the walk begins there
      next_q <= wb_dat_i;
    end
  end

  // shadow copies of words two and three for the latch at start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_rdata_w2_q <= RST_WORD;
      mem_rdata_w3_q <= RST_WORD;
    end else if (wr && pend_q && wb_adr_i == REG_RX_W2) begin
      mem_rdata_w2_q <= wb_dat_i;
    end else if (wr && pend_q && wb_adr_i == REG_RX_W3) begin
      mem_rdata_w3_q <= wb_dat_i;
    end
  end

  // size travels beside the fifo word; fifo holds addresses only
  logic [BS_W-1:0] size_fifo_q [FIFO_D];
  logic [2:0] sw_q, sr_q;
  wire fifo_push = push_v && push_ok;
  wire fifo_pop = fifo_out_valid && (!out_valid_q || buf_ready_i);

  dde_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(push_data),
    .in_valid_i(push_v),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(!out_valid_q || buf_ready_i)
  );

  always_ff @(posedge clk_i) begin
    if (fifo_push) begin
      size_fifo_q[sw_q] <= (step_q == DDE_BUF1) ? sz1_q : sz2_q;
    end
  end

  // output register holds the offered entry until the sink takes it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_q <= '0;
      sr_q <= '0;
      out_valid_q <= 1'b0;
      out_addr_q <= RST_WORD;
      size_out_q <= '0;
      tx_own_o <= 1'b0;
    end else begin
      tx_own_o <= tx_w0_q[TX_OWN_BIT];
      if (fifo_push) begin
        sw_q <= sw_q + 3'd1;
      end
      if (fifo_pop) begin
        sr_q <= sr_q + 3'd1;
        out_valid_q <= 1'b1;
        out_addr_q <= fifo_out;
        size_out_q <= size_fifo_q[sr_q];
      end else if (buf_ready_i) begin
        out_valid_q <= 1'b0;
      end
    end
  end

  assign buf_addr_o = out_addr_q;
  assign buf_size_o = size_out_q;
  assign buf_valid_o = out_valid_q;
endmodule

// ==== rtl/dde_pkg.sv ====
// package: descriptor field layouts, register map and shared types
package dde_pkg;
  // receive control word fields
  localparam int RX_RING_WRAP_BIT = 25;
  localparam int RX_CHAINED_BIT = 24;
  localparam int RX_BS2_HI = 21;
  localparam int RX_BS2_LO = 11;
  localparam int RX_BS1_HI = 10;
  localparam int RX_BS1_LO = 0;
  localparam int BS_W = 11;
  // transmit status word fields
  localparam int TX_OWN_BIT = 31;
  localparam int TX_ES_BIT = 15;
  localparam int TX_JABBER_BIT = 14;
  localparam int TX_LOSS_CAR_BIT = 11;
  localparam int TX_NO_CAR_BIT = 10;
  localparam int TX_LATE_COL_BIT = 9;
  localparam int TX_EXC_COL_BIT = 8;
  localparam int TX_UNDERFLOW_BIT = 1;
  // receive status word fields
  localparam int RX_FF_BIT = 30;
  localparam int RX_RF_BIT = 11;
  localparam int RX_CS_BIT = 6;
  localparam int RX_FT_BIT = 5;
  localparam int RX_DB_BIT = 2;
  localparam int RX_CE_BIT = 1;
  // descriptor word byte offsets
  localparam logic [31:0] DESC_W1_OFS = 32'h0000_0004;
  localparam logic [31:0] DESC_W2_OFS = 32'h0000_0008;
  localparam logic [31:0] DESC_W3_OFS = 32'h0000_000C;
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
  // register byte offsets (wishbone)
  localparam logic [7:0] REG_RX_BASE = 8'h00;
  localparam logic [7:0] REG_RX_W1 = 8'h04;
  localparam logic [7:0] REG_RX_W2 = 8'h08;
  localparam logic [7:0] REG_RX_W3 = 8'h0C;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam logic [7:0] REG_RX_NEXT = 8'h14;
  localparam logic [7:0] REG_RX_BUF = 8'h18;
  localparam logic [7:0] REG_TX_W0 = 8'h1C;
  localparam logic [7:0] REG_TX_ERR = 8'h20;
  localparam logic [7:0] REG_RX_STAT = 8'h24;
  localparam logic [7:0] REG_STATE = 8'h28;
  localparam logic [7:0] REG_RX_COND = 8'h2C;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;
  // command bits
  localparam int CMD_RX_STEP = 0;
  localparam int CMD_TX_DONE = 1;
  localparam int CMD_RX_COMPLETE = 2;
  // completion condition bits
  localparam int COND_OVERFLOW = 0;
  localparam int COND_LATE_COL = 1;
  localparam int COND_WATCHDOG = 2;
  localparam int COND_SHORT_RUNT = 3;
  localparam int FIFO_W = 32;
  localparam int FIFO_D = 8;

  typedef struct packed {
    logic [31:0] addr;
    logic [BS_W-1:0] size;
  } dde_buf_t;

  typedef enum logic [1:0] {
    DDE_BUF1,
    DDE_BUF2,
    DDE_NEXT
  } dde_step_t;
endpackage

// ==== rtl/dde_fifo.sv ====
// file: small valid/ready fifo for buffer requests
`timescale 1ns/10ps
module dde_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  assign in_ready_o = (cnt_q != (AW+1)'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rp_q];
endmodule

// ==== rtl/dde_desc_mem.sv ====
// file: one small register-read memory holding the fetched rx words
`timescale 1ns/10ps
module dde_desc_mem import dde_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [1:0] waddr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [1:0] raddr_i,
  output logic [31:0] rdata_o
);
  logic [31:0] mem_q [4];

  for (genvar i = 0; i < 4; i++) begin : g_word
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mem_q[i] <= RST_WORD;
      end else if (we_i && waddr_i == 2'(i)) begin
        mem_q[i] <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= RST_WORD;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule

// ==== tb/dde_engine_sva.sv ====
// checker: port-level properties of the descriptor engine
`timescale 1ns/10ps
module dde_engine_chk import dde_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [31:0] buf_addr_o,
  input wire logic [BS_W-1:0] buf_size_o,
  input wire logic buf_valid_o,
  input wire logic buf_ready_i,
  input wire logic tx_own_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic wr_ack = wb_ack_o && wb_we_i;
  wire logic rd_ack = wb_ack_o && !wb_we_i;
  wire logic tx_wr = wr_ack && wb_adr_i == REG_TX_W0 && wb_sel_i[3];
  wire logic done_wr = wr_ack && wb_adr_i == REG_CMD;
  wire logic [31:0] d = wb_dat_o;
  wire logic err_or = d[1] | d[8] | d[9] | d[10] | d[11] | d[14];

  ack_delay_a: assert property ($rose(wb_cyc_i && wb_stb_i) |->
    !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o) else $error("ack not at 2");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  buf_hold_a: assert property (buf_valid_o && !buf_ready_i |=> buf_valid_o
    && $stable(buf_addr_o) && $stable(buf_size_o)) else $error("entry moved");
  size_nonzero_a: assert property (buf_valid_o |-> buf_size_o != 0)
    else $error("zero size buffer offered");
  own_set_a: assert property (tx_wr && wb_dat_i[TX_OWN_BIT] |->
    ##[1:2] tx_own_o) else $error("ownership not taken");
  own_clear_a: assert property (done_wr && wb_dat_i[CMD_TX_DONE] |->
    ##[1:2] !tx_own_o) else $error("ownership not released");
  reset_idle_a: assert property ($fell(rst_i) |-> !buf_valid_o && !tx_own_o)
    else $error("outputs busy after reset");
  unmapped_zero_a: assert property (rd_ack && wb_adr_i > REG_RX_COND |->
    d == BAD_ADDR_DATA) else $error("unmapped read not zero");
  err_summary_a: assert property (rd_ack && wb_adr_i == REG_TX_ERR |->
    d[TX_ES_BIT] == err_or) else $error("error summary wrong");
  cover property (buf_valid_o && buf_ready_i);
  cover property (buf_valid_o && !buf_ready_i);
  cover property ($fell(tx_own_o));
endmodule

bind dde_engine dde_engine_chk chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .buf_addr_o(buf_addr_o),
  .buf_size_o(buf_size_o), .buf_valid_o(buf_valid_o),
  .buf_ready_i(buf_ready_i), .tx_own_o(tx_own_o));

// ==== tb/dde_host_model.sv ====
// host memory model: sink for offered receive buffers
`timescale 1ns/10ps
module dde_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic slow_i,
  output logic buf_ready_o
);
  // ready changes only after an edge; slow mode accepts every other cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_ready_o <= 1'b0;
    end else begin
      buf_ready_o <= !stall_i && !(slow_i && buf_ready_o);
    end
  end
endmodule

// ==== tb/test_dma_descriptor_format.sv ====
// testbench: descriptor walk, buffer fifo, tx status and registers
`timescale 1ns/10ps
module test_dma_descriptor_format import dde_pkg::*;;
  typedef struct packed {
    logic [31:0] ctl;
    logic [31:0] p1;
    logic [31:0] p2;
    logic [1:0] n;
  } dde_row_t;
  localparam logic [31:0] BASE = 32'h0000_1000;
  localparam logic [31:0] STAT = 32'h4000_0866;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic stall = 1'b1;
  logic slow = 1'b0;
  logic [31:0] wb_dat_o, buf_addr_o, rd, cur;
  logic wb_ack_o, buf_valid_o, buf_ready_i, tx_own_o;
  logic [BS_W-1:0] buf_size_o;
  logic [42:0] got[$], ex[$];
  int miscompares = 0;
  int comparisons = 0;
  int eb[6] = '{1, 8, 9, 10, 11, 14};
  logic [31:0] cx[4] = '{32'h4000_0020, 32'h4000_0066, 32'h4000_0060,
    32'h0000_0846};
  dde_row_t rows[6] = '{
    '{32'h0001_0010, 32'h0000_2000, 32'h0000_3000, 2'd2},
    '{32'h0000_4000, 32'h0000_2000, 32'h0000_3000, 2'd1},
    '{32'h0000_0004, 32'h0000_2000, 32'h0000_3000, 2'd1},
    '{32'h0100_A00C, 32'h0000_2000, 32'h0000_5000, 2'd1},
    '{32'h0200_2004, 32'h0000_2000, 32'h0000_3000, 2'd2},
    '{32'h0300_0008, 32'h0000_2000, 32'h0000_6000, 2'd1}};

  dde_engine uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .buf_addr_o(buf_addr_o), .buf_size_o(buf_size_o),
    .buf_valid_o(buf_valid_o), .buf_ready_i(buf_ready_i),
    .tx_own_o(tx_own_o));
  dde_host_model host (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
    .slow_i(slow), .buf_ready_o(buf_ready_i));

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (buf_valid_o === 1'b1 && buf_ready_i === 1'b1)
      got.push_back({buf_addr_o, buf_size_o});

  task automatic final_report;
    $display("counts: %0d comparisons, %0d miscompares", comparisons,
      miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [42:0] e,
    input logic [42:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle; the request holds until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] dt);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= dt;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      final_report();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // poll the state word until the masked busy/nonempty bits clear
  task automatic idle(input logic [2:0] m);
    int n;
    n = 0;
    do begin
      wb(1'b0, REG_STATE, 32'h0000_0000);
      n++;
    end while ((rd[2:0] & m) !== 3'b000 && n < 30);
    if (n >= 30) begin
      miscompares++;
      final_report();
    end
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    stall <= 1'b0;
    wb(1'b1, REG_RX_BASE, BASE);
    cur = BASE;
    foreach (rows[i]) begin
      wb(1'b1, REG_RX_W1, rows[i].ctl);
      wb(1'b1, REG_RX_W2, rows[i].p1);
      wb(1'b1, REG_RX_W3, rows[i].p2);
      slow <= (i % 2 == 1);
      got.delete();
      ex.delete();
      wb(1'b1, REG_CMD, 32'h0000_0001);
      idle(3'b110);
      if (rows[i].ctl[RX_BS1_HI:RX_BS1_LO] != 0)
        ex.push_back({rows[i].p1, rows[i].ctl[RX_BS1_HI:RX_BS1_LO]});
      if (!rows[i].ctl[RX_CHAINED_BIT] && rows[i].ctl[RX_BS2_HI:0] > 2047)
        ex.push_back({rows[i].p2, rows[i].ctl[RX_BS2_HI:RX_BS2_LO]});
      chk("entries", 43'(rows[i].n), 43'(got.size()));
      foreach (ex[k])
        chk("entry", ex[k], got.size() > k ? got[k] : '0);
      cur = rows[i].ctl[RX_RING_WRAP_BIT] ? BASE : rows[i].ctl[RX_CHAINED_BIT]
        ? rows[i].p2 : cur + DESC_STRIDE;
      wb(1'b0, REG_RX_NEXT, 32'h0000_0000);
      chk("next", 43'(cur), 43'(rd));
      $display("row %0d done", i);
    end
    stall <= 1'b1;
    slow <= 1'b0;
    got.delete();
    wb(1'b1, REG_RX_W1, rows[0].ctl);
    wb(1'b1, REG_RX_W3, rows[0].p2);
    repeat (4) begin
      wb(1'b1, REG_CMD, 32'h0000_0001);
      idle(3'b100);
    end
    // one single-buffer step more: output register holds one, fifo eight
    wb(1'b1, REG_RX_W1, rows[2].ctl);
    wb(1'b1, REG_CMD, 32'h0000_0001);
    idle(3'b100);
    wb(1'b0, REG_STATE, 32'h0000_0000);
    chk("fifo full", 43'h2, 43'(rd[1:0]));
    stall <= 1'b0;
    idle(3'b110);
    chk("drained", 43'd9, 43'(got.size()));
    chk("last", {rows[0].p2, 11'd32}, got.size() > 7 ? got[7] : '0);
    $display("fifo test done");
    wb(1'b1, REG_TX_W0, 32'h8000_0000);
    repeat (2) @(posedge clk_i);
    chk("own set", 43'd1, 43'(tx_own_o));
    wb(1'b1, REG_CMD, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    chk("own clear", 43'd0, 43'(tx_own_o));
    foreach (eb[k]) begin
      wb(1'b1, REG_TX_ERR, 32'h0000_0001 << eb[k]);
      wb(1'b0, REG_TX_ERR, 32'h0000_0000);
      chk("summary", 43'd1, 43'(rd[TX_ES_BIT]));
    end
    wb(1'b1, REG_TX_ERR, 32'h0000_0000);
    wb(1'b0, REG_TX_ERR, 32'h0000_0000);
    chk("summary off", 43'd0, 43'(rd[TX_ES_BIT]));
    foreach (cx[k]) begin
      wb(1'b1, REG_RX_COND, 32'h0000_0001 << k);
      wb(1'b1, REG_RX_STAT, STAT);
      wb(1'b0, REG_RX_STAT, 32'h0000_0000);
      chk("rx status", 43'(cx[k]), 43'(rd & STAT));
    end
    wb(1'b1, 8'h30, 32'hFFFF_FFFF);
    wb(1'b0, 8'h30, 32'h0000_0000);
    chk("unmapped", 43'(BAD_ADDR_DATA), 43'(rd));
    $display("tx and status tests done");
    wb(1'b1, REG_TX_W0, 32'h8000_0000);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_RX_W1, 32'h0000_0000);
    chk("own reset", 43'd0, 43'(tx_own_o));
    chk("word reset", 43'(RST_WORD), 43'(rd));
    $display("reset test done");
    final_report();
  end
endmodule
